// file: rtl/arhpc_pkg.sv
package arhpc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] RANGE_FILTER_CONFIG_ADDR    = 8'h0E;
	localparam logic [7:0] HIGHPASS_CUTOFF_SELECT_ADDR = 8'h0F;
	localparam logic [7:0] RANGE_FILTER_CONFIG_RST     = 8'h00;
	localparam logic [7:0] HIGHPASS_CUTOFF_SELECT_RST  = 8'h00;
	localparam logic [7:0] RANGE_WRITE_MASK            = 8'h13;
	localparam logic [7:0] CUTOFF_WRITE_MASK           = 8'h33;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int HP_OUT_BIT      = 4;
	localparam int RANGE_LSB       = 0;
	localparam int TAP_BYPASS_BIT  = 5;
	localparam int TAP_LOWPASS_BIT = 4;
	localparam int CUTOFF_LSB      = 0;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ARHPC_RANGE_2G  = 2'h0,
		ARHPC_RANGE_4G  = 2'h1,
		ARHPC_RANGE_8G  = 2'h2,
		ARHPC_RANGE_RSV = 2'h3
	} arhpc_range_t;

	typedef enum logic [1:0] {
		ARHPC_OS_NORMAL  = 2'h0,
		ARHPC_OS_LOWNOIS = 2'h1,
		ARHPC_OS_HIRES   = 2'h2,
		ARHPC_OS_LOWPWR  = 2'h3
	} arhpc_osmode_t;

	// Rate codes 0..7 = 800,400,200,100,50,12.5,6.25,1.56 Hz
	localparam logic [2:0] RATE_50HZ = 3'h4;

	// Cutoff encoded as log2 step below 16 Hz: 0=16 Hz ... 9=0.031 Hz
	localparam logic [3:0] STEP_8HZ  = 4'h1;
	localparam logic [3:0] STEP_2HZ  = 4'h3;
	localparam logic [3:0] STEP_HALF = 4'h5;
	localparam logic [3:0] STEP_QTR  = 4'h6;

endpackage

// file: rtl/arhpc_cfg_if.sv
`timescale 1ns/10ps
interface arhpc_cfg_if;
	logic [2:0] rate;
	logic [1:0] mode;
	logic [1:0] code;
	logic [3:0] step;

	modport requester (output rate, output mode, output code, input step);
	modport mapper (input rate, input mode, input code, output step);
endinterface

// file: rtl/arhpc_cutoff_map.sv
`timescale 1ns/10ps
module arhpc_cutoff_map (
	arhpc_cfg_if.mapper cfg
);

	// ----------------------------------------------------------------
	// Code 00 cutoff per rate and mode
	// ----------------------------------------------------------------
	function automatic logic [3:0] base_step(input logic [2:0] rate, input logic [1:0] mode);
		logic [3:0] r;
		r = {1'b0, rate};
		case (mode)
			arhpc_pkg::ARHPC_OS_HIRES:   base_step = 4'h0;
			arhpc_pkg::ARHPC_OS_LOWPWR:  base_step = (rate > arhpc_pkg::RATE_50HZ) ?
				arhpc_pkg::STEP_QTR : r;
			arhpc_pkg::ARHPC_OS_LOWNOIS: base_step = (rate > arhpc_pkg::RATE_50HZ) ?
				arhpc_pkg::STEP_HALF : ((rate == 3'h0) ? 4'h0 : 4'(r - 4'h1));
			default:                     base_step = (rate > arhpc_pkg::RATE_50HZ) ?
				arhpc_pkg::STEP_2HZ : ((rate == 3'h0) ? 4'h0 : 4'(r - 4'h1));
		endcase
	endfunction

	// Each code step halves the cutoff
	// halving per code
	assign cfg.step = 4'(base_step(cfg.rate, cfg.mode) + {2'h0, cfg.code});

endmodule

// file: rtl/arhpc_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - High-pass select routes filtered data to the sample output
// - Two-bit range: 2g, 4g, 8g, reserved
// - Reset gives 2g range, unfiltered output
// - Tap path high-pass unless bypass bit set
// - Tap low-pass applied only when enabled
// - Two-bit cutoff code, resets to 00
// - Each cutoff code step halves cutoff
// - High-resolution cutoff independent of rate
// - Code 00 cutoff follows rate and mode
module arhpc_top #(
	parameter int SAMPLE_W = 12
) (
	// Clock and reset
	input  wire logic                sys_clk_i,
	input  wire logic                nrst_i,
	// Register port
	input  wire logic [7:0]          reg_addr_i,
	input  wire logic                reg_wr_i,
	input  wire logic [7:0]          reg_wdata_i,
	input  wire logic                reg_rd_i,
	output logic      [7:0]          reg_rdata_o,
	// Rate and oversampling from other registers
	input  wire logic [2:0]          output_sample_rate_i,
	input  wire logic [1:0]          osmode_i,
	// Sample streams
	input  wire logic                sample_valid_i,
	input  wire logic [SAMPLE_W-1:0] raw_sample_i,
	input  wire logic [SAMPLE_W-1:0] hp_sample_i,
	input  wire logic [SAMPLE_W-1:0] tap_hp_sample_i,
	input  wire logic [SAMPLE_W-1:0] tap_hp_lp_sample_i,
	input  wire logic [SAMPLE_W-1:0] tap_raw_lp_sample_i,
	// Data path results
	output logic                     out_valid_o,
	output logic      [SAMPLE_W-1:0] out_sample_o,
	output logic      [SAMPLE_W-1:0] tap_sample_o,
	output logic      [1:0]          full_scale_range_o,
	output logic                     highpass_output_select_o,
	output logic                     tap_highpass_bypass_o,
	output logic                     tap_lowpass_enable_o,
	output logic      [3:0]          cutoff_step_o
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]          range_filter_config_q,    range_filter_config_d;
	logic [7:0]          highpass_cutoff_select_q, highpass_cutoff_select_d;
	logic [7:0]          rdata_q,                  rdata_d;
	logic                valid_q;
	logic [SAMPLE_W-1:0] out_q,                    out_d;
	logic [SAMPLE_W-1:0] tap_q,                    tap_d;
	logic [3:0]          step_q;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire logic wr_range  = reg_wr_i && (reg_addr_i == arhpc_pkg::RANGE_FILTER_CONFIG_ADDR);
	wire logic wr_cutoff = reg_wr_i && (reg_addr_i == arhpc_pkg::HIGHPASS_CUTOFF_SELECT_ADDR);
	wire logic rd_range  = reg_rd_i && (reg_addr_i == arhpc_pkg::RANGE_FILTER_CONFIG_ADDR);
	wire logic rd_cutoff = reg_rd_i && (reg_addr_i == arhpc_pkg::HIGHPASS_CUTOFF_SELECT_ADDR);

	assign range_filter_config_d = wr_range ?
		(reg_wdata_i & arhpc_pkg::RANGE_WRITE_MASK) : range_filter_config_q;
	assign highpass_cutoff_select_d = wr_cutoff ?
		(reg_wdata_i & arhpc_pkg::CUTOFF_WRITE_MASK) : highpass_cutoff_select_q;

	assign rdata_d = rd_range  ? range_filter_config_q :
	                 rd_cutoff ? highpass_cutoff_select_q :
	                 reg_rd_i  ? 8'h00 : rdata_q;

	// ----------------------------------------------------------------
	// Fields
	// ----------------------------------------------------------------
	wire logic       hp_sel   = range_filter_config_q[arhpc_pkg::HP_OUT_BIT];
	wire logic [1:0] range_f  = range_filter_config_q[arhpc_pkg::RANGE_LSB +: 2];
	wire logic       tap_byp  = highpass_cutoff_select_q[arhpc_pkg::TAP_BYPASS_BIT];
	wire logic       tap_lpf  = highpass_cutoff_select_q[arhpc_pkg::TAP_LOWPASS_BIT];
	wire logic [1:0] code_f   = highpass_cutoff_select_q[arhpc_pkg::CUTOFF_LSB +: 2];

	assign out_d = sample_valid_i ? (hp_sel ? hp_sample_i : raw_sample_i) : out_q;

	assign tap_d = !sample_valid_i ? tap_q :
	               tap_byp ? (tap_lpf ? tap_raw_lp_sample_i : raw_sample_i) :
	                         (tap_lpf ? tap_hp_lp_sample_i  : tap_hp_sample_i);

	// ----------------------------------------------------------------
	// Cutoff mapping
	// ----------------------------------------------------------------
	arhpc_cfg_if cfg ();
	assign cfg.rate = output_sample_rate_i;
	assign cfg.mode = osmode_i;
	assign cfg.code = code_f;

	arhpc_cutoff_map u_map (
		.cfg (cfg)
	);

	// ----------------------------------------------------------------
	// Flops
	// ----------------------------------------------------------------
	// reset defaults
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			range_filter_config_q    <= arhpc_pkg::RANGE_FILTER_CONFIG_RST;
			highpass_cutoff_select_q <= arhpc_pkg::HIGHPASS_CUTOFF_SELECT_RST;
			rdata_q                  <= 8'h00;
			valid_q                  <= 1'b0;
			out_q                    <= '0;
			tap_q                    <= '0;
			step_q                   <= 4'h0;
		end else begin
			range_filter_config_q    <= range_filter_config_d;
			highpass_cutoff_select_q <= highpass_cutoff_select_d;
			rdata_q                  <= rdata_d;
			valid_q                  <= sample_valid_i;
			out_q                    <= out_d;
			tap_q                    <= tap_d;
			step_q                   <= cfg.step;
		end
	end

	assign reg_rdata_o              = rdata_q;
	assign out_valid_o              = valid_q;
	assign out_sample_o             = out_q;
	assign tap_sample_o             = tap_q;
	assign full_scale_range_o       = range_f;
	assign highpass_output_select_o = hp_sel;
	assign tap_highpass_bypass_o    = tap_byp;
	assign tap_lowpass_enable_o     = tap_lpf;
	assign cutoff_step_o            = step_q;

endmodule

// file: test/arhpc_host.sv
`timescale 1ns/10ps
module arhpc_host (
	input  wire logic       sys_clk_i,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o
);
	initial {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = '0;
	// Held for one edge, then strobes drop to 0 and address and data lines show inverted values
	task automatic xfer(logic w, logic [7:0] a, d);
		@(posedge sys_clk_i);
		{reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} <= {w, !w, a, d};
		@(posedge sys_clk_i);
		{reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} <= {2'b00, ~a, ~d};
	endtask
endmodule

// file: test/arhpc_top_assertions.sv
`timescale 1ns/10ps
module arhpc_top_chk #(parameter int SAMPLE_W = 12) (
	input wire logic sys_clk_i, nrst_i, reg_wr_i, reg_rd_i, sample_valid_i, out_valid_o,
	input wire logic highpass_output_select_o, tap_highpass_bypass_o, tap_lowpass_enable_o,
	input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
	input wire logic [1:0] osmode_i, full_scale_range_o,
	input wire logic [3:0] cutoff_step_o,
	input wire logic [SAMPLE_W-1:0] raw_sample_i, hp_sample_i, tap_hp_lp_sample_i,
	input wire logic [SAMPLE_W-1:0] out_sample_o, tap_sample_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	a_rst_clear: assert property (disable iff (1'b0) !nrst_i |=> reg_rdata_o == 8'h00
		&& full_scale_range_o == 2'h0 && !highpass_output_select_o && cutoff_step_o == 4'h0)
		else $error("reset state");
	a_out_filtered: assert property (sample_valid_i && highpass_output_select_o |=>
		out_valid_o && out_sample_o == $past(hp_sample_i)) else $error("out source");
	a_tap_bypass: assert property (sample_valid_i && tap_highpass_bypass_o &&
		!tap_lowpass_enable_o |=> tap_sample_o == $past(raw_sample_i)) else $error("tap bypass");
	a_tap_lowpass: assert property (sample_valid_i && !tap_highpass_bypass_o &&
		tap_lowpass_enable_o |=> tap_sample_o == $past(tap_hp_lp_sample_i)) else $error("tap lpf");
	a_range_write: assert property (reg_wr_i && reg_addr_i == 8'h0E |=>
		full_scale_range_o == $past(reg_wdata_i[1:0])) else $error("range write");
	a_tap_write: assert property (reg_wr_i && reg_addr_i == 8'h0F |=> {tap_highpass_bypass_o,
		tap_lowpass_enable_o} == $past(reg_wdata_i[5:4])) else $error("tap write");
	a_unmap_read: assert property (reg_rd_i && reg_addr_i[7:1] != 7'h07 |=>
		reg_rdata_o == 8'h00) else $error("unmapped read");
	a_hires_fixed: assert property (osmode_i == 2'h2 ##1 (osmode_i == 2'h2 && !reg_wr_i)[*2]
		|=> $stable(cutoff_step_o)) else $error("hires cutoff");
endmodule
bind arhpc_top arhpc_top_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.*);

// file: test/tb.sv
`timescale 1ns/10ps
module tb;
	logic sys_clk_i = 0, nrst_i = 0, sample_valid_i = 0, reg_wr_i, reg_rd_i, out_valid_o;
	logic highpass_output_select_o, tap_highpass_bypass_o, tap_lowpass_enable_o;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [2:0] output_sample_rate_i = 0;
	logic [1:0] osmode_i = 0, full_scale_range_o;
	logic [3:0] cutoff_step_o;
	logic [11:0] raw_sample_i = 12'h100, hp_sample_i = 12'h200, tap_hp_sample_i = 12'h300;
	logic [11:0] tap_hp_lp_sample_i = 12'h400, tap_raw_lp_sample_i = 12'h500;
	logic [11:0] out_sample_o, tap_sample_o;
	int errors = 0, n_checks = 0;
	arhpc_top dut (.*);
	arhpc_host host (.sys_clk_i, .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
		.reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
	initial forever #2.5 sys_clk_i = ~sys_clk_i;
	task automatic chk(string s, logic [11:0] e, g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic rdchk(logic [7:0] a, e);
		host.xfer(1'b0, a, 8'h00);
		#1 chk("rdata", 12'(e), 12'(reg_rdata_o));
	endtask
	task automatic t_regs();
		logic [7:0] d;
		rdchk(8'h0E, 8'h00);
		for (int c = 0; c < 4; c++) begin
			d = 8'hEC | 8'(c * 17);
			host.xfer(1'b1, 8'h0E, d);
			rdchk(8'h0E, {3'h0, d[4], 2'h0, d[1:0]});
			chk("range", 12'(c), 12'(full_scale_range_o));
		end
		host.xfer(1'b1, 8'h20, 8'hFF);
		rdchk(8'h20, 8'h00);
		$display("register test done");
	endtask
	task automatic t_path();
		logic [11:0] e_tap;
		for (int i = 0; i < 4; i++) begin
			host.xfer(1'b1, 8'h0E, 8'(i * 16));
			host.xfer(1'b1, 8'h0F, 8'(i * 16));
			sample_valid_i <= 1'b1;
			@(posedge sys_clk_i);
			sample_valid_i <= 1'b0;
			e_tap = i[1] ? (i[0] ? 12'h500 : 12'h100) : 12'h300 + 12'(i * 256);
			#1 chk("out", i[0] ? 12'h200 : 12'h100, out_sample_o);
			chk("tap", e_tap, tap_sample_o);
			chk("valid", 12'h001, 12'(out_valid_o));
			chk("hpsel", 12'(i[0]), 12'(highpass_output_select_o));
			chk("bypass", 12'(i[1]), 12'(tap_highpass_bypass_o));
			chk("lowpass", 12'(i[0]), 12'(tap_lowpass_enable_o));
			@(posedge sys_clk_i);
			#1 chk("valid", 12'h000, 12'(out_valid_o));
			chk("out hold", i[0] ? 12'h200 : 12'h100, out_sample_o);
			chk("tap hold", e_tap, tap_sample_o);
		end
		$display("path test done");
	endtask
	task automatic t_reset();
		@(posedge sys_clk_i);
		nrst_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		#1 chk("out rst", 12'h000, out_sample_o);
		chk("tap rst", 12'h000, tap_sample_o);
		chk("hpsel rst", 12'h000, 12'(highpass_output_select_o));
		chk("range rst", 12'h000, 12'(full_scale_range_o));
		chk("bypass rst", 12'h000, 12'(tap_highpass_bypass_o));
		chk("lowpass rst", 12'h000, 12'(tap_lowpass_enable_o));
		rdchk(8'h0E, 8'h00);
		rdchk(8'h0F, 8'h00);
		chk("step rst", 12'h006, 12'(cutoff_step_o));
		$display("reset test done");
	endtask
	function automatic int stp(int r, m, c);
		if (m == 2) return c;
		if (m == 3) return (r > 4 ? 6 : r) + c;
		return (r < 2 ? 0 : r > 4 ? (m == 1 ? 5 : 3) : r - 1) + c;
	endfunction
	task automatic t_cut();
		rdchk(8'h0F, 8'h00);
		for (int c = 0; c < 4; c++) begin
			host.xfer(1'b1, 8'h0F, 8'hCC | 8'(c));
			rdchk(8'h0F, 8'(c));
			for (int k = 0; k < 32; k++) begin
				@(posedge sys_clk_i);
				{osmode_i, output_sample_rate_i} <= 5'(k);
				repeat (2) @(posedge sys_clk_i);
				#1 chk("step", 12'(stp(k % 8, k / 8, c)), 12'(cutoff_step_o));
			end
		end
		$display("cutoff test done");
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		t_cut();
		t_regs();
		t_path();
		t_reset();
		end_sim();
	end
	initial begin
		#20000;
		errors++;
		end_sim();
	end
endmodule
